// ### rtl/clkgen_cfg.svh
// constants of the cpu clock generator control: bit positions, reset values, counts
// assumes inclusion by bare name from rtl files only
`ifndef CLKGEN_CFG_SVH
`define CLKGEN_CFG_SVH

// processor clock control
`define PROC_CLK_RESET      8'h02
`define PROC_CLK_STOP_BIT   7
`define PROC_CLK_DIV_BIT    1
// suboscillator mode
`define SUBOSC_MODE_RESET   8'h00
`define SUBOSC_FRC_BIT      1
`define SUBOSC_STOP_BIT     0
// subclock select
`define SUBCLK_SEL_RESET    8'h00
`define SUBCLK_STATUS_BIT   5
`define SUBCLK_SRC_BIT      4

// divider ratios
`define MAIN_SLOW_DIV       2'h3
// switch latency in old-clock cycles
`define LAT_FAST_TO_SLOW    9'h004
`define LAT_FAST_TO_SUB     9'h132
`define LAT_SLOW_TO_SUB     9'h04D
`define LAT_OTHER           9'h002
// main oscillator stabilisation, 2**15 main periods
`define STAB_EDGES          32768

`endif

// ### rtl/clkgen_pkg.sv
// types of the cpu clock generator control
// assumes clkgen_cfg.svh holds the numeric constants
package clkgen_pkg;

   typedef enum logic [1:0] {
      CK_FAST = 2'b00,
      CK_SLOW = 2'b01,
      CK_SUB  = 2'b10
   } cpu_clk_t;

   typedef enum logic [0:0] {
      SW_IDLE = 1'b0,
      SW_WAIT = 1'b1
   } sw_state_t;

endpackage

// ### rtl/cpu_clock_generator_control.sv
// cpu clock generator control: source select, oscillator control, switch latency
// assumes oscillator outputs arrive as asynchronous pins; software bits as plain ports
// Contract
// - reset loads processor clock control with slow mode
// - main oscillator stopped while reset held low
// - three cpu clock choices: fast, slow, sub
// - main clock selected allows stop and halt
// - feedback resistor bit disconnects sub resistor
// - writing sub stop bit halts sub oscillator
// - source select bit picks subsystem clock
// - main stop bit halts main oscillator
// - sub clock selected: halt allowed, stop refused
// - peripheral clocks derived from main clock
// - sub clock only to timer, watch, display
// - main-clocked peripherals stop with main clock
// - cpu clock from divide and source bits
// - old clock runs on after selection change
// - switch latency 4, 306, 77 or 2 old cycles
// - 2**15 main periods wait after reset
// - execution starts at slow main clock
// - clearing main stop bit restarts main oscillator
// - encoding 00 fast, 01 div4, 1x sub/2
// - status bit shows cpu really on sub
// - main stop set only while sub selected
// - reset clears sub mode and select registers
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_cfg.svh"

module cpu_clock_generator_control
   import clkgen_pkg::*;
#(
   parameter int STAB_EDGES = `STAB_EDGES
) (
   input  wire logic       CLK_SYS_I,
   input  wire logic       RST_N_I,
   input  wire logic       MAIN_OSC_CLK_I,
   input  wire logic       SUB_OSC_CLK_I,
   input  wire logic       PROC_CLK_WR_I,
   input  wire logic [7:0] PROC_CLK_WDATA_I,
   input  wire logic       SUBOSC_MODE_WR_I,
   input  wire logic [7:0] SUBOSC_MODE_WDATA_I,
   input  wire logic       SUBCLK_SEL_WR_I,
   input  wire logic [7:0] SUBCLK_SEL_WDATA_I,
   output var  logic [7:0] PROC_CLK_RDATA_O,
   output var  logic [7:0] SUBOSC_MODE_RDATA_O,
   output var  logic [7:0] SUBCLK_SEL_RDATA_O,
   output var  logic       MAIN_OSC_EN_O,
   output var  logic       SUB_OSC_EN_O,
   output var  logic       SUB_FEEDBACK_EN_O,
   output var  logic       CPU_RUN_O,
   output var  logic       CPU_TICK_O,
   output var  logic       PERIPH_TICK_O,
   output var  logic       SUB_TICK_O,
   output var  logic       STOP_ALLOWED_O,
   output var  logic       HALT_ALLOWED_O
);

   // reset release through two flip-flops
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   logic main_edge;
   logic sub_edge;

   osc_edge_sync u_main_sync (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (MAIN_OSC_CLK_I),
      .rise_o  (main_edge)
   );

   osc_edge_sync u_sub_sync (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (SUB_OSC_CLK_I),
      .rise_o  (sub_edge)
   );

   // software visible bits
   logic      main_stop_reg, main_stop_next;
   logic      div_sel_reg, div_sel_next;
   logic      fr_off_reg, fr_off_next;
   logic      sub_stop_reg, sub_stop_next;
   logic      src_sel_reg, src_sel_next;
   // clock state
   cpu_clk_t  cur_clk_reg, cur_clk_next;
   cpu_clk_t  tgt_clk;
   sw_state_t sw_state_reg, sw_state_next;
   logic [8:0]  sw_cnt_reg, sw_cnt_next;
   logic [1:0]  mdiv_reg, mdiv_next;
   logic        sdiv_reg, sdiv_next;
   logic [15:0] stab_cnt_reg, stab_cnt_next;
   logic        stab_done_reg, stab_done_next;
   logic        main_en_reg, main_en_next;
   logic        sub_en_reg, sub_en_next;
   logic        cpu_tick_reg, cpu_tick_next;
   logic        periph_tick_reg, periph_tick_next;
   logic        sub_tick_reg, sub_tick_next;
   logic        stop_ok_reg, stop_ok_next;
   logic        old_tick;
   logic        skip_reg, skip_next;

   // selection decode
   always_comb begin
      if (src_sel_reg) begin
         tgt_clk = CK_SUB;
      end else if (div_sel_reg) begin
         tgt_clk = CK_SLOW;
      end else begin
         tgt_clk = CK_FAST;
      end
   end

   // one pulse per cpu clock period of the clock now in use
   always_comb begin
      case (cur_clk_reg)
         CK_FAST: old_tick = main_edge && !skip_reg;
         CK_SLOW: old_tick = main_edge && (mdiv_reg == `MAIN_SLOW_DIV);
         CK_SUB:  old_tick = sub_edge && sdiv_reg;
         default: old_tick = 1'b0;
      endcase
   end

   always_comb begin
      main_stop_next   = main_stop_reg;
      div_sel_next     = div_sel_reg;
      fr_off_next      = fr_off_reg;
      sub_stop_next    = sub_stop_reg;
      src_sel_next     = src_sel_reg;
      cur_clk_next     = cur_clk_reg;
      sw_state_next    = sw_state_reg;
      sw_cnt_next      = sw_cnt_reg;
      mdiv_next        = main_edge ? mdiv_reg + 2'h1 : mdiv_reg;
      sdiv_next        = sub_edge ? !sdiv_reg : sdiv_reg;
      skip_next        = skip_reg && !main_edge;
      stab_cnt_next    = stab_cnt_reg;
      stab_done_next   = stab_done_reg;
      if (PROC_CLK_WR_I) begin
         div_sel_next = PROC_CLK_WDATA_I[`PROC_CLK_DIV_BIT];
         if (!PROC_CLK_WDATA_I[`PROC_CLK_STOP_BIT]) begin
            main_stop_next = 1'b0;
         end else if (cur_clk_reg == CK_SUB) begin
            main_stop_next = 1'b1;
         end
      end
      if (SUBOSC_MODE_WR_I) begin
         fr_off_next   = SUBOSC_MODE_WDATA_I[`SUBOSC_FRC_BIT];
         sub_stop_next = SUBOSC_MODE_WDATA_I[`SUBOSC_STOP_BIT];
      end
      if (SUBCLK_SEL_WR_I) begin
         src_sel_next = SUBCLK_SEL_WDATA_I[`SUBCLK_SRC_BIT];
      end
      // stabilisation wait counts main periods after release
      if (!stab_done_reg && main_edge) begin
         if (stab_cnt_reg == 16'(STAB_EDGES - 1)) begin
            stab_done_next = 1'b1;
         end else begin
            stab_cnt_next = stab_cnt_reg + 16'h0001;
         end
      end
      // switch only at an old-clock period boundary
      case (sw_state_reg)
         SW_IDLE: begin
            if (tgt_clk != cur_clk_reg) begin
               sw_state_next = SW_WAIT;
               if (cur_clk_reg == CK_FAST && tgt_clk == CK_SLOW) begin
                  sw_cnt_next = `LAT_FAST_TO_SLOW;
               end else if (cur_clk_reg == CK_FAST && tgt_clk == CK_SUB) begin
                  sw_cnt_next = `LAT_FAST_TO_SUB;
               end else if (cur_clk_reg == CK_SLOW && tgt_clk == CK_SUB) begin
                  sw_cnt_next = `LAT_SLOW_TO_SUB;
               end else begin
                  sw_cnt_next = `LAT_OTHER;
               end
            end
         end
         SW_WAIT: begin
            if (old_tick) begin
               if (sw_cnt_reg <= 9'h001) begin
                  cur_clk_next  = tgt_clk;
                  // new clock starts with a full period
                  skip_next     = 1'b1;
                  mdiv_next     = 2'h0;
                  sdiv_next     = 1'b0;
                  sw_state_next = SW_IDLE;
                  sw_cnt_next   = 9'h000;
               end else begin
                  sw_cnt_next = sw_cnt_reg - 9'h001;
               end
            end
         end
         default: begin
            sw_state_next = SW_IDLE;
         end
      endcase
      main_en_next     = !main_stop_next;
      sub_en_next      = !sub_stop_reg;
      cpu_tick_next    = stab_done_reg && old_tick;
      periph_tick_next = main_edge && main_en_reg;
      sub_tick_next    = sub_edge && sub_en_reg;
      stop_ok_next     = stab_done_next && (cur_clk_next != CK_SUB);
   end

   always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         main_stop_reg   <= 1'(`PROC_CLK_RESET >> `PROC_CLK_STOP_BIT);
         div_sel_reg     <= 1'(`PROC_CLK_RESET >> `PROC_CLK_DIV_BIT);
         fr_off_reg      <= 1'(`SUBOSC_MODE_RESET >> `SUBOSC_FRC_BIT);
         sub_stop_reg    <= 1'(`SUBOSC_MODE_RESET >> `SUBOSC_STOP_BIT);
         src_sel_reg     <= 1'(`SUBCLK_SEL_RESET >> `SUBCLK_SRC_BIT);
         cur_clk_reg     <= CK_SLOW;
         sw_state_reg    <= SW_IDLE;
         sw_cnt_reg      <= 9'h000;
         mdiv_reg        <= 2'h0;
         sdiv_reg        <= 1'b0;
         stab_cnt_reg    <= 16'h0000;
         stab_done_reg   <= 1'b0;
         main_en_reg     <= 1'b0;
         sub_en_reg      <= 1'b0;
         cpu_tick_reg    <= 1'b0;
         periph_tick_reg <= 1'b0;
         sub_tick_reg    <= 1'b0;
         stop_ok_reg     <= 1'b0;
         skip_reg        <= 1'b0;
      end else begin
         main_stop_reg   <= main_stop_next;
         div_sel_reg     <= div_sel_next;
         fr_off_reg      <= fr_off_next;
         sub_stop_reg    <= sub_stop_next;
         src_sel_reg     <= src_sel_next;
         cur_clk_reg     <= cur_clk_next;
         sw_state_reg    <= sw_state_next;
         sw_cnt_reg      <= sw_cnt_next;
         mdiv_reg        <= mdiv_next;
         sdiv_reg        <= sdiv_next;
         stab_cnt_reg    <= stab_cnt_next;
         stab_done_reg   <= stab_done_next;
         main_en_reg     <= main_en_next;
         sub_en_reg      <= sub_en_next;
         cpu_tick_reg    <= cpu_tick_next;
         periph_tick_reg <= periph_tick_next;
         sub_tick_reg    <= sub_tick_next;
         stop_ok_reg     <= stop_ok_next;
         skip_reg        <= skip_next;
      end
   end

   // read back; fixed bits read zero
   always_comb begin
      PROC_CLK_RDATA_O = 8'h00;
      PROC_CLK_RDATA_O[`PROC_CLK_STOP_BIT] = main_stop_reg;
      PROC_CLK_RDATA_O[`PROC_CLK_DIV_BIT]  = div_sel_reg;
      SUBOSC_MODE_RDATA_O = 8'h00;
      SUBOSC_MODE_RDATA_O[`SUBOSC_FRC_BIT]  = fr_off_reg;
      SUBOSC_MODE_RDATA_O[`SUBOSC_STOP_BIT] = sub_stop_reg;
      SUBCLK_SEL_RDATA_O = 8'h00;
      SUBCLK_SEL_RDATA_O[`SUBCLK_STATUS_BIT] = (cur_clk_reg == CK_SUB);
      SUBCLK_SEL_RDATA_O[`SUBCLK_SRC_BIT]    = src_sel_reg;
   end

   assign MAIN_OSC_EN_O     = main_en_reg;
   assign SUB_OSC_EN_O      = sub_en_reg;
   assign SUB_FEEDBACK_EN_O = !fr_off_reg;
   assign CPU_RUN_O         = stab_done_reg;
   assign CPU_TICK_O        = cpu_tick_reg;
   assign PERIPH_TICK_O     = periph_tick_reg;
   assign SUB_TICK_O        = sub_tick_reg;
   assign STOP_ALLOWED_O    = stop_ok_reg;
   assign HALT_ALLOWED_O    = stab_done_reg;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!rst_n);

   a_main_osc_release: assert property ($rose(rst_n) |-> !MAIN_OSC_EN_O ##1 MAIN_OSC_EN_O)
      else $error("main oscillator not held then started around reset");
   a_slow_before_run: assert property (!CPU_RUN_O && (cur_clk_reg != CK_SLOW) |-> src_sel_reg || !div_sel_reg)
      else $error("clock left slow mode without a selection change");
   a_wait_after_rst: assert property ($rose(rst_n) |-> !CPU_RUN_O [*8])
      else $error("cpu ran without stabilisation wait");
   a_stab_count: assert property ($rose(stab_done_reg) |-> $past(stab_cnt_reg) == 16'(STAB_EDGES - 1))
      else $error("stabilisation wait has wrong length");
   a_tick_gated: assert property (!stab_done_reg |=> !CPU_TICK_O)
      else $error("cpu tick during stabilisation wait");
   a_stop_refused_sub: assert property (cur_clk_reg == CK_SUB |-> !STOP_ALLOWED_O && HALT_ALLOWED_O == CPU_RUN_O)
      else $error("stop allowed on sub clock");
   a_stop_ok_main: assert property (CPU_RUN_O && cur_clk_reg != CK_SUB |-> STOP_ALLOWED_O && HALT_ALLOWED_O)
      else $error("standby refused on main clock");
   a_main_stop_guard: assert property (PROC_CLK_WR_I && PROC_CLK_WDATA_I[7] && cur_clk_reg != CK_SUB && !main_stop_reg |=> !main_stop_reg ##1 MAIN_OSC_EN_O)
      else $error("main stop accepted off sub clock");
   a_main_restart: assert property (PROC_CLK_WR_I && !PROC_CLK_WDATA_I[7] |=> !main_stop_reg && MAIN_OSC_EN_O)
      else $error("main oscillator not restarted");
   a_main_halt: assert property (PROC_CLK_WR_I && PROC_CLK_WDATA_I[7] && cur_clk_reg == CK_SUB |=> !MAIN_OSC_EN_O)
      else $error("main oscillator not stopped");
   a_sub_stop: assert property (SUBOSC_MODE_WR_I && SUBOSC_MODE_WDATA_I[0] |=> ##1 !SUB_OSC_EN_O)
      else $error("sub oscillator not stopped");
   a_feedback_off: assert property (SUBOSC_MODE_WR_I |=> SUB_FEEDBACK_EN_O == !$past(SUBOSC_MODE_WDATA_I[1]))
      else $error("feedback resistor select wrong");
   a_lat_fast_slow: assert property (sw_state_reg == SW_IDLE && cur_clk_reg == CK_FAST && tgt_clk == CK_SLOW |=> sw_cnt_reg == 9'h004)
      else $error("fast to slow latency wrong");
   a_lat_fast_sub: assert property (sw_state_reg == SW_IDLE && cur_clk_reg == CK_FAST && tgt_clk == CK_SUB |=> sw_cnt_reg == 9'h132)
      else $error("fast to sub latency wrong");
   a_switch_on_tick: assert property ($changed(cur_clk_reg) |-> $past(old_tick) && $past(sw_state_reg) == SW_WAIT)
      else $error("clock switched off a period boundary");
   a_old_clock_held: assert property (sw_state_reg == SW_IDLE && tgt_clk != cur_clk_reg |=> $stable(cur_clk_reg) [*2])
      else $error("new clock took effect at once");
   a_status_bit: assert property (SUBCLK_SEL_RDATA_O[5] == (cur_clk_reg == CK_SUB) && (!src_sel_reg || tgt_clk == CK_SUB))
      else $error("sub status bit wrong");
   a_periph_stop: assert property (!MAIN_OSC_EN_O |=> !PERIPH_TICK_O)
      else $error("peripheral tick with main stopped");

   c_fast_to_sub: cover property (cur_clk_reg == CK_FAST ##1 cur_clk_reg == CK_SUB);
   c_main_stopped: cover property (cur_clk_reg == CK_SUB && !MAIN_OSC_EN_O);
   c_run_start: cover property ($rose(CPU_RUN_O));
   c_back_to_main: cover property (cur_clk_reg == CK_SUB ##1 cur_clk_reg != CK_SUB);

endmodule

`default_nettype wire

// ### rtl/osc_edge_sync.sv
// oscillator pin synchroniser with rising edge pulse
// assumes pin is asynchronous to clk_i and much slower than it
`timescale 1ns/1ps
`default_nettype none

module osc_edge_sync (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic pin_i,
   output var  logic rise_o
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg;
   logic lvl_next;
   logic rise_reg;
   logic rise_next;

   // level changes only once stages two and three agree
   always_comb begin
      lvl_next  = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      rise_next = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg   <= 1'b0;
         s2_reg   <= 1'b0;
         s3_reg   <= 1'b0;
         lvl_reg  <= 1'b0;
         rise_reg <= 1'b0;
      end else begin
         s1_reg   <= pin_i;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         lvl_reg  <= lvl_next;
         rise_reg <= rise_next;
      end
   end

   assign rise_o = rise_reg;

endmodule

`default_nettype wire

// ### test/cpu_clock_generator_control_tb.sv
// self-checking bench of the cpu clock generator control
// assumes oscillator pins made here and a shortened stabilisation count
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_generator_control_tb;

   localparam int STAB = 16;
   localparam int T_F  = 200;
   localparam int T_S  = 800;
   localparam int T_U  = 61036;

   logic       clk, rst_n, mosc, sosc, pwr, swr, cwr;
   logic [7:0] pd, sd, cd, prd, srd, crd, d;
   logic       men, sen, fben, run, ctk, ptk, stk, stp, hlt;
   logic [7:0] m_proc, m_osc, m_sel;
   int         m_sub, error_cnt, n_tests, seed_v, p, s, k, bad, gap;

   cpu_clock_generator_control #(.STAB_EDGES(STAB)) i_cpu_clock_generator_control (
      .CLK_SYS_I           (clk),
      .RST_N_I             (rst_n),
      .MAIN_OSC_CLK_I      (mosc),
      .SUB_OSC_CLK_I       (sosc),
      .PROC_CLK_WR_I       (pwr),
      .PROC_CLK_WDATA_I    (pd),
      .SUBOSC_MODE_WR_I    (swr),
      .SUBOSC_MODE_WDATA_I (sd),
      .SUBCLK_SEL_WR_I     (cwr),
      .SUBCLK_SEL_WDATA_I  (cd),
      .PROC_CLK_RDATA_O    (prd),
      .SUBOSC_MODE_RDATA_O (srd),
      .SUBCLK_SEL_RDATA_O  (crd),
      .MAIN_OSC_EN_O       (men),
      .SUB_OSC_EN_O        (sen),
      .SUB_FEEDBACK_EN_O   (fben),
      .CPU_RUN_O           (run),
      .CPU_TICK_O          (ctk),
      .PERIPH_TICK_O       (ptk),
      .SUB_TICK_O          (stk),
      .STOP_ALLOWED_O      (stp),
      .HALT_ALLOWED_O      (hlt)
   );

   always #20 clk = ~clk;

   // oscillators stand still while disabled
   initial begin
      #7;
      forever begin
         #100;
         mosc = (men === 1'b1) ? ~mosc : 1'b0;
      end
   end

   initial begin
      #3;
      forever begin
         #15259;
         sosc = (sen === 1'b1) ? ~sosc : 1'b0;
      end
   end

   task test_done();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      n_tests++;
      if (got !== ex) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   function automatic bit near(input int dt, input int per);
      return (dt > per - 60) && (dt < per + 60);
   endfunction

   task chk_regs();
      chk("proc_clk", m_proc, prd);
      chk("subosc_mode", m_osc, srd);
      chk("subclk_sel", (m_sel & 8'h10) | ((m_sub != 0) ? 8'h20 : 8'h00), crd);
      chk("main_en", {7'h0, ~m_proc[7]}, {7'h0, men});
      chk("sub_en", {7'h0, ~m_osc[0]}, {7'h0, sen});
      chk("feedback_en", {7'h0, ~m_osc[1]}, {7'h0, fben});
   endtask

   // one write strobe, then the model follows
   task wr(input int r, input logic [7:0] dv);
      @(negedge clk);
      case (r)
         0: begin
            pwr = 1'b1;
            pd = dv;
            m_proc = dv & ((m_sub != 0) ? 8'h82 : 8'h02);
         end
         1: begin
            swr = 1'b1;
            sd = dv;
            m_osc = dv & 8'h03;
         end
         default: begin
            cwr = 1'b1;
            cd = dv;
            m_sel = dv & 8'h10;
         end
      endcase
      @(negedge clk);
      pwr = 1'b0;
      swr = 1'b0;
      cwr = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task tick(output time t);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ctk !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         error_cnt++;
         $display("ERROR cpu_tick expected pulse seen none");
      end
      t = $time;
   endtask

   // old ticks until the new period shows, then one more period
   task sw(input int per, input int lim);
      time t0, t1;
      int  n;
      n = 0;
      tick(t1);
      do begin
         t0 = t1;
         tick(t1);
         n++;
      end while (!near(int'(t1 - t0), per) && n < lim + 3);
      t0 = t1;
      tick(t1);
      n_tests++;
      if (n > lim + 2 || !near(int'(t1 - t0), per)) begin
         error_cnt++;
         $display("ERROR cpu_period expected %0d seen %0d after %0d", per, t1 - t0, n);
      end
   endtask

   task pulses(input int n);
      p = 0;
      s = 0;
      repeat (n) begin
         @(negedge clk);
         p += (ptk === 1'b1) ? 1 : 0;
         s += (stk === 1'b1) ? 1 : 0;
      end
   endtask

   // no two cpu ticks closer than a fast period allows
   always @(negedge clk) begin
      if (ctk === 1'b1) begin
         if (gap < 3 && run === 1'b1) begin
            error_cnt++;
            $display("ERROR cpu_tick_gap expected 3 seen %0d", gap);
         end
         gap = 0;
      end else begin
         gap++;
      end
   end

   initial begin
      #3_000_000;
      error_cnt++;
      $display("ERROR watchdog expected finish seen hang");
      test_done();
   end

   initial begin
      clk = 0; rst_n = 0; mosc = 0; sosc = 0; pwr = 0; swr = 0; cwr = 0;
      pd = 8'h00; sd = 8'h00; cd = 8'h00; gap = 10; bad = 0;
      error_cnt = 0; n_tests = 0;
      m_proc = 8'h02; m_osc = 8'h00; m_sel = 8'h00; m_sub = 0;
      seed_v = $urandom(34622);
      repeat (8) @(negedge clk);
      chk("proc_clk", 8'h02, prd);
      chk("main_en", 8'h00, {7'h0, men});
      chk("subosc_mode", 8'h00, srd);
      chk("subclk_sel", 8'h00, crd);
      rst_n = 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         k++;
         bad += (ctk === 1'b1) ? 1 : 0;
      end while (run !== 1'b1 && k < 1000);
      chk("cpu_run", 8'h01, {7'h0, run});
      chk("run_wait_long", 8'h01, {7'h0, k >= (STAB - 1) * 5});
      chk("tick_before_run", 8'h00, 8'(bad));
      chk_regs();
      chk("stop_ok", 8'h01, {7'h0, stp});
      chk("halt_ok", 8'h01, {7'h0, hlt});
      sw(T_S, 2);
      pulses(50);
      chk("periph_ticks", 8'h01, {7'h0, p >= 9 && p <= 11});
      wr(0, 8'h00);
      sw(T_F, 2);
      wr(0, 8'h02);
      sw(T_S, 4);
      repeat (4) begin
         d = 8'($urandom);
         wr(0, d);
         chk_regs();
      end
      wr(0, 8'h80);
      chk_regs();
      wr(0, 8'h00);
      sw(T_F, 8);
      repeat (6) begin
         d = 8'($urandom);
         wr(1, d);
         chk_regs();
      end
      wr(1, 8'h01);
      chk_regs();
      pulses(1600);
      chk("sub_ticks_off", 8'h00, 8'(s));
      wr(1, 8'h02);
      chk_regs();
      wr(1, 8'h00);
      pulses(1600);
      chk("sub_ticks_on", 8'h01, {7'h0, s >= 1});
      wr(2, 8'h30);
      sw(T_U, 306);
      m_sub = 1;
      chk_regs();
      chk("stop_ok", 8'h00, {7'h0, stp});
      chk("halt_ok", 8'h01, {7'h0, hlt});
      wr(0, 8'h80);
      chk_regs();
      pulses(50);
      chk("periph_ticks", 8'h00, 8'(p));
      wr(0, 8'h00);
      chk_regs();
      repeat (100) @(negedge clk);
      wr(2, 8'h00);
      sw(T_F, 2);
      m_sub = 0;
      chk_regs();
      chk("stop_ok", 8'h01, {7'h0, stp});
      // slow main to sub switch
      wr(0, 8'h02);
      sw(T_S, 4);
      wr(2, 8'h10);
      sw(T_U, 77);
      m_sub = 1;
      chk_regs();
      chk("stop_ok", 8'h00, {7'h0, stp});
      test_done();
   end

endmodule

`default_nettype wire
